/* hdl/mdt_pkg.sv */
// Constants for the MII data path timing block.
// Assumes a single 20 MHz core clock; all latencies become whole core cycles.
package mdt_pkg;

  // ****************************************
  // Time base
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int BIT100_NS     = 10;
  localparam int CNT_W         = 4;

  // ****************************************
  // Line latencies in bit times
  // ****************************************
  localparam int TX_LAT_BITS  = 6;
  localparam int CRS_ON_BITS  = 20;
  localparam int RXD_LAT_BITS = 24;
  localparam int CRS_OFF_BITS = 24;

  // Least times: round up to whole cycles
  localparam int TX_LAT_CYC  = (TX_LAT_BITS * BIT100_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CRS_ON_CYC  = (CRS_ON_BITS * BIT100_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RXD_LAT_CYC = (RXD_LAT_BITS * BIT100_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CRS_OFF_CYC = (CRS_OFF_BITS * BIT100_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIPE_LEN    = 8;

  // ****************************************
  // Nibble clock phases
  // ****************************************
  localparam int HALF10_NS   = 200;
  localparam int HALF100_NS  = 20;
  localparam int RX_SETUP_NS = 100;
  localparam int HALF10_I    = HALF10_NS / CLK_PERIOD_NS;
  localparam int HALF100_I   = (HALF100_NS / CLK_PERIOD_NS) < 1 ? 1 : HALF100_NS / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] HALF10_CYC  = HALF10_I[CNT_W-1:0];
  localparam logic [CNT_W-1:0] HALF100_CYC = HALF100_I[CNT_W-1:0];
  localparam int RX_SETUP_CYC = (RX_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Pin synchroniser layout
  // ****************************************
  localparam int SY_TXD     = 0;
  localparam int SY_TXEN    = 4;
  localparam int SY_SPD     = 5;
  localparam int SY_RXNIB   = 6;
  localparam int SY_RXACT   = 10;
  localparam int SY_RXCLK   = 11;
  localparam int SY_W       = 12;

endpackage : mdt_pkg

/* hdl/mdt_clkgen.sv */
// Nibble clock phase generator with glitch-free source switching.
// Assumes the caller supplies a synchronised edge strobe for the external source.
module mdt_clkgen
  import mdt_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Control
  input  wire logic [CNT_W-1:0] half_cyc_in,
  input  wire logic             use_ext_in,
  input  wire logic             ext_edge_in,
  // Clock out
  output logic                  clk_out,
  output logic                  rise_out,
  output logic                  fall_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             lvl;
    logic             pend;
    logic             rise;
    logic             fall;
  } mdt_cg_t;

  mdt_cg_t st_ff;
  mdt_cg_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.rise = 1'b0;
    nxt_st.fall = 1'b0;
    if (!use_ext_in) begin
      nxt_st.pend = 1'b0;
    end else if (ext_edge_in) begin
      nxt_st.pend = 1'b1;
    end
    // A phase never ends before its full count; waiting for the source only stretches it
    if (st_ff.cnt < half_cyc_in - 4'h1) begin
      nxt_st.cnt = st_ff.cnt + 4'h1;
    end else if (!use_ext_in || st_ff.pend || ext_edge_in) begin
      nxt_st.cnt  = '0;
      nxt_st.lvl  = ~st_ff.lvl;
      nxt_st.pend = 1'b0;
      nxt_st.rise = ~st_ff.lvl;
      nxt_st.fall = st_ff.lvl;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign clk_out  = st_ff.lvl;
  assign rise_out = st_ff.rise;
  assign fall_out = st_ff.fall;

endmodule : mdt_clkgen

/* hdl/mdt_datapath.sv */
// MII-side data path timing of a 10/100 line transceiver: nibble clocks,
// transmit sampling and line latency, receive carrier sense and data latency.
// Assumes MAC and line signals are asynchronous pins; line side is nibble-wide.
module mdt_datapath
  import mdt_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  // Mode
  input  wire logic       speed_100_in,
  // MII transmit
  input  wire logic [3:0] txd_in,
  input  wire logic       tx_en_in,
  output logic            tx_clk_out,
  // MII receive
  output logic            rx_clk_out,
  output logic [3:0]      rxd_out,
  output logic            rx_dv_out,
  output logic            crs_out,
  // Line transmit
  output logic [3:0]      line_txd_out,
  output logic            line_tx_en_out,
  // Line receive
  input  wire logic [3:0] line_rx_nib_in,
  input  wire logic       line_rx_act_in,
  input  wire logic       line_rx_clk_in
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [SY_W-1:0]              meta;
    logic [SY_W-1:0]              sync;
    logic                         rclk_prev;
    logic [4:0]                   tx_cap;
    logic [PIPE_LEN-1:0][4:0]     tx_pipe;
    logic [PIPE_LEN-1:0][4:0]     rx_hist;
    logic [3:0]                   line_txd;
    logic                         line_tx_en;
    logic                         crs;
    logic                         rx_dv;
    logic [3:0]                   rxd;
    logic                         tclk;
    logic                         rclk;
  } mdt_st_t;

  mdt_st_t st_ff;
  mdt_st_t nxt_st;

  // ****************************************
  // Nibble clocks
  // ****************************************
  logic [CNT_W-1:0] half_cyc;
  logic             tx_lvl;
  logic             tx_rise;
  logic             tx_fall;
  logic             rx_lvl;
  logic             rx_fall;
  logic             rclk_edge;
  logic             spd100;

  assign spd100    = st_ff.sync[SY_SPD];
  assign half_cyc  = spd100 ? HALF100_CYC : HALF10_CYC;
  assign rclk_edge = st_ff.sync[SY_RXCLK] ^ st_ff.rclk_prev;

  mdt_clkgen u_tx_clk (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n),
    .half_cyc_in (half_cyc),
    .use_ext_in  (1'b0),
    .ext_edge_in (1'b0),
    .clk_out     (tx_lvl),
    .rise_out    (tx_rise),
    .fall_out    (tx_fall)
  );

  // Follows the recovered clock while carrier is present, the reference otherwise
  mdt_clkgen u_rx_clk (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n),
    .half_cyc_in (half_cyc),
    .use_ext_in  (st_ff.sync[SY_RXACT]),
    .ext_edge_in (rclk_edge),
    .clk_out     (rx_lvl),
    .rise_out    (),
    .fall_out    (rx_fall)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_st      = st_ff;
    // Pins pass two stages before any logic looks at them
    nxt_st.meta = {line_rx_clk_in, line_rx_act_in, line_rx_nib_in, speed_100_in,
                   tx_en_in, txd_in};
    nxt_st.sync      = st_ff.meta;
    nxt_st.rclk_prev = st_ff.sync[SY_RXCLK];
    // Output clocks re-registered so every pin comes from a flop
    nxt_st.tclk = tx_lvl;
    nxt_st.rclk = rx_lvl;

    // MAC changes on the rise, so 10 Mb/s capture waits for the fall
    if (spd100 ? tx_rise : tx_fall) begin
      nxt_st.tx_cap = {st_ff.sync[SY_TXEN], st_ff.sync[SY_TXD +: 4]};
    end
    nxt_st.tx_pipe    = {st_ff.tx_pipe[PIPE_LEN-2:0], st_ff.tx_cap};
    nxt_st.line_tx_en = st_ff.tx_pipe[TX_LAT_CYC-1][4];
    nxt_st.line_txd   = st_ff.tx_pipe[TX_LAT_CYC-1][4] ?
                        st_ff.tx_pipe[TX_LAT_CYC-1][3:0] : 4'h0;

    nxt_st.rx_hist = {st_ff.rx_hist[PIPE_LEN-2:0],
                      st_ff.sync[SY_RXACT], st_ff.sync[SY_RXNIB +: 4]};
    // Shorter rise delay than fall delay, so the OR gives both edges
    nxt_st.crs = st_ff.rx_hist[CRS_ON_CYC-1][4] | st_ff.rx_hist[CRS_OFF_CYC-1][4];
    // Changing on the fall leaves a full phase of setup before the rise
    if (rx_fall) begin
      nxt_st.rx_dv = st_ff.rx_hist[RXD_LAT_CYC-1][4];
      nxt_st.rxd   = st_ff.rx_hist[RXD_LAT_CYC-1][4] ?
                     st_ff.rx_hist[RXD_LAT_CYC-1][3:0] : 4'h0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign tx_clk_out     = st_ff.tclk;
  assign rx_clk_out     = st_ff.rclk;
  assign rxd_out        = st_ff.rxd;
  assign rx_dv_out      = st_ff.rx_dv;
  assign crs_out        = st_ff.crs;
  assign line_txd_out   = st_ff.line_txd;
  assign line_tx_en_out = st_ff.line_tx_en;

endmodule : mdt_datapath

/* dv/mdt_assertions.sv */
// Port-level timing checks for the data path block.
// Assumes speed only changes while reset is held.
module mdt_assertions (
  // Watched ports
  input wire logic       clk_in,
  input wire logic       arst_n_in,
  input wire logic       speed_100_in,
  input wire logic       tx_en_in,
  input wire logic       tx_clk_out,
  input wire logic       rx_clk_out,
  input wire logic [3:0] rxd_out,
  input wire logic       rx_dv_out,
  input wire logic       crs_out,
  input wire logic       line_tx_en_out,
  input wire logic       line_rx_act_in
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // ****
  // Checks
  // ****
  sequence s_slow_rise;
    !speed_100_in && $rose(tx_clk_out);
  endsequence
  sequence s_slow_fall;
    !speed_100_in && $fell(tx_clk_out);
  endsequence
  chk_tx_start: assert property ($rose(tx_en_in) |-> !line_tx_en_out[*3] ##[1:14] line_tx_en_out)
    else $error("line start late or early");
  chk_tx_end: assert property ($fell(tx_en_in) |-> line_tx_en_out[*3] ##[1:14] !line_tx_en_out)
    else $error("line end late or early");
  chk_crs_on: assert property ($rose(line_rx_act_in) |-> !crs_out[*4] ##[1:4] crs_out)
    else $error("carrier sense rise timing");
  chk_crs_off: assert property ($fell(line_rx_act_in) |-> crs_out[*5] ##[1:4] !crs_out)
    else $error("carrier sense fall timing");
  chk_slow_high: assert property (s_slow_rise |-> tx_clk_out[*4] ##1 !tx_clk_out)
    else $error("slow clock high phase");
  chk_slow_low: assert property (s_slow_fall |-> !tx_clk_out[*4] ##1 tx_clk_out)
    else $error("slow clock low phase");
  chk_fast_clock: assert property (speed_100_in && $rose(tx_clk_out) |=> !tx_clk_out ##1 tx_clk_out)
    else $error("fast clock period");
  chk_rx_phase: assert property (!speed_100_in && $changed(rx_clk_out) |-> ##1 $stable(rx_clk_out)[*3])
    else $error("receive clock phase shortened");
  chk_rx_setup: assert property (!speed_100_in && ($changed(rx_dv_out) || $changed(rxd_out))
      |-> !rx_clk_out[*3])
    else $error("receive data too close to clock rise");
endmodule : mdt_assertions

bind mdt_datapath mdt_assertions u_chk (.clk_in, .arst_n_in, .speed_100_in, .tx_en_in,
  .tx_clk_out, .rx_clk_out, .rxd_out, .rx_dv_out, .crs_out, .line_tx_en_out, .line_rx_act_in);

/* dv/mdt_mac_model.sv */
// MAC model: drives transmit pins, collects received nibbles.
// Assumes the block supplies both nibble clocks.
module mdt_mac_model (
  // Clocks and receive pins
  input  wire logic       clk_in,
  input  wire logic       tx_clk_in,
  input  wire logic       rx_clk_in,
  input  wire logic [3:0] rxd_in,
  input  wire logic       rx_dv_in,
  // Transmit pins
  output logic [3:0]      txd_out,
  output logic            tx_en_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] rx_q[$];
  initial begin
    txd_out = 4'h0;
    tx_en_out = 1'b0;
  end
  always @(posedge rx_clk_in) if (rx_dv_in) rx_q.push_back(rxd_in);
  // ****
  // Transmit: change just after the clock rise
  // ****
  task automatic send(input logic [3:0] nib[$]);
    foreach (nib[i]) begin
      @(posedge tx_clk_in);
      @(negedge clk_in);
      txd_out = nib[i];
      tx_en_out = 1'b1;
    end
    @(posedge tx_clk_in);
    @(negedge clk_in);
    tx_en_out = 1'b0;
    txd_out = ~nib[$]; // Released data must not look valid
  endtask : send
endmodule : mdt_mac_model

/* dv/testbench.sv */
// Bench top: clock, reset, MAC model, line stimulus and checks.
// Assumes line nibbles arrive one per 400 ns line clock.
module testbench import mdt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_in, arst_n_in, speed_100_in, tx_en_in, tx_clk_out, rx_clk_out;
  logic       rx_dv_out, crs_out, line_tx_en_out, line_rx_act_in, line_rx_clk_in;
  logic [3:0] txd_in, rxd_out, line_txd_out, line_rx_nib_in;
  int         err_total, cmp_count, hi_cnt;
  logic [3:0] seen_q[$];
  mdt_datapath uut (.clk_in, .arst_n_in, .speed_100_in, .txd_in, .tx_en_in, .tx_clk_out,
    .rx_clk_out, .rxd_out, .rx_dv_out, .crs_out, .line_txd_out, .line_tx_en_out,
    .line_rx_nib_in, .line_rx_act_in, .line_rx_clk_in);
  mdt_mac_model u_mac (.clk_in, .tx_clk_in(tx_clk_out), .rx_clk_in(rx_clk_out),
    .rxd_in(rxd_out), .rx_dv_in(rx_dv_out), .txd_out(txd_in), .tx_en_out(tx_en_in));
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) if (line_tx_en_out) begin
    hi_cnt++;
    if (seen_q.size() == 0 || seen_q[$] !== line_txd_out) seen_q.push_back(line_txd_out);
  end
  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic do_reset(input logic spd);
    @(negedge clk_in);
    arst_n_in = 1'b0;
    speed_100_in = spd;
    repeat (5) @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (8) @(negedge clk_in);
  endtask : do_reset
  task automatic complete_run();
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  // ****
  // Scenarios
  // ****
  task automatic scen_tx(input logic spd);
    logic [3:0] nib[$] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
    do_reset(spd);
    hi_cnt = 0;
    seen_q = {};
    u_mac.send(nib);
    repeat (24) @(negedge clk_in);
    check(16'(hi_cnt), 16'(nib.size() * (spd ? 2 * HALF100_I : 2 * HALF10_I)));
    check(16'(seen_q.size()), 16'(nib.size()));
    foreach (nib[i]) check(16'(seen_q[i]), 16'(nib[i]));
  endtask : scen_tx
  task automatic scen_rx(input logic spd);
    logic [3:0] nib[$] = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE};
    int         k;
    do_reset(spd);
    u_mac.rx_q = {};
    line_rx_act_in = 1'b1;
    foreach (nib[i]) begin
      line_rx_nib_in = nib[i];
      #200 line_rx_clk_in = 1'b1;
      #200 line_rx_clk_in = 1'b0;
    end
    line_rx_act_in = 1'b0;
    line_rx_nib_in = ~nib[$];
    repeat (40) @(negedge clk_in);
    check(16'(crs_out), 16'h0);
    k = 0;
    while (k < u_mac.rx_q.size() && u_mac.rx_q[k] !== nib[0]) k++;
    // Last nibble may be cut by the end of the frame
    for (int i = 0; i < nib.size() - 1; i++) check(16'(u_mac.rx_q[k+i]), 16'(nib[i]));
  endtask : scen_rx
  initial begin
    clk_in = 1'b0;
    arst_n_in = 1'b0;
    speed_100_in = 1'b0;
    line_rx_act_in = 1'b0;
    line_rx_clk_in = 1'b0;
    line_rx_nib_in = 4'h0;
    err_total = 0;
    cmp_count = 0;
    hi_cnt = 0;
    for (int s = 0; s < 2; s++) begin
      scen_tx(s[0]);
      scen_rx(s[0]);
    end
    complete_run();
  end
  initial begin
    #400000;
    err_total++;
    complete_run();
  end
endmodule : testbench
